// File: hw/discrete_io_trigger_sync.sv
// core discretes, avionics shunt discretes, triggers and syncs behind APB
// What this block does
// RL1 - eight core discrete lines per core, each input or output
// RL2 - every core line has its own output enable
// RL3 - core input readback stays live while the line drives
// RL4 - core outputs released at reset; enabled by write or enable
// RL5 - lines owned by trigger or sync leave general purpose use
// RL6 - trigger condition from masked lines, each with own polarity
// RL7 - selectors 1 to 8 address core lines 0 to 7
// RL8 - core lines 0-2 are triggers A-C, lines 4-6 syncs A-C
// RL9 - software can fire any trigger like the external condition
// RL10 - sixteen avionics shunt lines as general purpose I/O
// RL11 - avionics pin drives and senses at once for verification
// RL12 - avionics input reads open (1) or ground (0)
// RL13 - faulted avionics output stays off until cleared and redriven
// RL14 - avionics outputs open after reset
// RL15 - selectors 17 to 32 address avionics lines 0 to 15
// RL16 - software waits about 30 us before checking avionics readback
// RL17 - per-line latched fault flag, cleared by a new drive command
// RL18 - trigger fires when all masked lines match; inputs synchronised
`timescale 1ns/10ps
`include "discrete_io_defines.svh"
module discrete_io_trigger_sync (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core discrete pins
   input wire logic [7:0] core_discrete_line_i,
   output logic [7:0] core_discrete_line_o,
   output logic [7:0] core_discrete_line_oe,
   // avionics shunt pins: oe high sinks the pin to ground
   input wire logic [15:0] avionics_shunt_line_i,
   output logic [15:0] avionics_shunt_line_oe,
   input wire logic [15:0] avionics_thermal_fault,
   // trigger and sync to protocol logic
   input wire logic [2:0] sync_request,
   output discrete_io_pkg::trig_out_t trig_sync,
   // interrupt
   output logic irq
);
   logic [7:0] core_out;
   logic [7:0] core_en;
   logic [15:0] av_out;
   logic [15:0] av_fault;
   logic [8:0] trig_mask;
   logic [8:0] trig_pol;
   logic [5:0] sync_ctrl;
   logic [2:0] sw_fire;
   logic [2:0] trig_q;
   logic [2:0] trig_rise;
   logic [5:0] irq_status;
   logic [5:0] irq_mask;
   logic [31:0] sel_rdata;
   logic [7:0] core_s1, core_s2, core_s3, core_in;
   logic [15:0] av_s1, av_s2, av_s3, av_in;
   logic [15:0] flt_s1, flt_s2, flt_s3, flt_in;
   logic [7:0] owned;
   logic [2:0] trig_hit;
   logic wr, rd;
   logic [5:0] cmd_sel;
   logic [3:0] cmd_op;
   logic cmd_val;
   logic cmd_go;
   logic [7:0] core_wr_hit;
   logic [15:0] av_wr_hit;
   logic addr_ok;

   // zero wait-state slave
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign cmd_sel = pwdata[`CMD_SEL_LSB +: 6];
   assign cmd_op = pwdata[`CMD_OP_LSB +: 4];
   assign cmd_val = pwdata[`CMD_VAL_BIT];
   assign cmd_go = wr && paddr == `REG_SEL_CMD;

   // three-stage pin sampling; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_s1 <= 8'h00;
         core_s2 <= 8'h00;
         core_s3 <= 8'h00;
         av_s1 <= 16'hFFFF;
         av_s2 <= 16'hFFFF;
         av_s3 <= 16'hFFFF;
         flt_s1 <= 16'h0000;
         flt_s2 <= 16'h0000;
         flt_s3 <= 16'h0000;
      end else if (clk_en) begin
         core_s1 <= core_discrete_line_i;
         core_s2 <= core_s1;
         core_s3 <= core_s2;
         av_s1 <= avionics_shunt_line_i;
         av_s2 <= av_s1;
         av_s3 <= av_s2;
         flt_s1 <= avionics_thermal_fault;
         flt_s2 <= flt_s1;
         flt_s3 <= flt_s2;
      end
   end

   // accept a change once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_in <= 8'h00;
         av_in <= 16'hFFFF;
         flt_in <= 16'h0000;
      end else if (clk_en) begin
         // RL3 readback stays live
         core_in <= (core_s2 & core_s3) | (core_in & (core_s2 | core_s3));
         // RL12 open reads 1, ground 0
         av_in <= (av_s2 & av_s3) | (av_in & (av_s2 | av_s3));
         flt_in <= (flt_s2 & flt_s3) | (flt_in & (flt_s2 | flt_s3));
      end
   end

   // selector decode per line
   genvar gi;
   generate
      for (gi = 0; gi < `CORE_LINES; gi++) begin : g_core_sel
         // RL7 selector 1..8 maps to line 0..7
         assign core_wr_hit[gi] = cmd_go &&
            cmd_sel == 6'(`SEL_CORE_FIRST + gi);
      end
      for (gi = 0; gi < `AV_LINES; gi++) begin : g_av_sel
         // RL15 selector 17..32 maps to line 0..15
         assign av_wr_hit[gi] = cmd_go && cmd_sel == 6'(`SEL_AV_FIRST + gi);
      end
   endgenerate

   // RL5 lines claimed by a trigger mask or sync enable
   assign owned = {1'b0, sync_ctrl[2:0],
                   1'b0, trig_mask[2:0] | trig_mask[5:3] | trig_mask[8:6]};

   // core discrete output value and enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_out <= 8'h00;
         // RL4 outputs released at reset
         core_en <= `CORE_EN_RESET;
      end else if (clk_en) begin
         for (int i = 0; i < `CORE_LINES; i++) begin
            // RL4 a write also enables
            if (core_wr_hit[i] && cmd_op == discrete_io_pkg::op_write) begin
               core_out[i] <= cmd_val;
               core_en[i] <= 1'b1;
            end else if (core_wr_hit[i] &&
                         cmd_op == discrete_io_pkg::op_enable) begin
               core_en[i] <= 1'b1;
            end else if (core_wr_hit[i] &&
                         cmd_op == discrete_io_pkg::op_release) begin
               core_en[i] <= 1'b0;
            end
         end
         if (wr && paddr == `REG_CORE_OUT) begin
            core_out <= pwdata[7:0];
            core_en <= core_en | pwdata[7:0];
         end
         if (wr && paddr == `REG_CORE_EN) begin
            core_en <= pwdata[7:0];
         end
      end
   end

   // RL1 RL2 eight lines, own enable each; RL5 sync lines by sync logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_discrete_line_o <= 8'h00;
         core_discrete_line_oe <= 8'h00;
      end else if (clk_en) begin
         for (int i = 0; i < `CORE_LINES; i++) begin
            core_discrete_line_o[i] <= core_out[i];
            core_discrete_line_oe[i] <= core_en[i] && !owned[i];
         end
         // RL8 sync A-C leave on lines 4-6
         for (int j = 0; j < `TRIG_COUNT; j++) begin
            if (sync_ctrl[j]) begin
               core_discrete_line_o[`SYNC_LINE_FIRST + j] <=
                  sync_request[j] ^ sync_ctrl[3 + j];
               core_discrete_line_oe[`SYNC_LINE_FIRST + j] <= 1'b1;
            end
         end
      end
   end

   // avionics drive and latched fault shutdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // RL14 outputs open after reset
         av_out <= `AV_OUT_RESET;
         av_fault <= 16'h0000;
      end else if (clk_en) begin
         for (int i = 0; i < `AV_LINES; i++) begin
            if (flt_in[i] && av_out[i]) begin
               // RL13 shutdown latches, drive dropped
               av_out[i] <= 1'b0;
               // RL17 latch the fault flag
               av_fault[i] <= 1'b1;
            end else if (av_wr_hit[i] &&
                         cmd_op == discrete_io_pkg::op_write) begin
               // RL13 redrive only once fault gone
               av_out[i] <= cmd_val && !flt_in[i];
               // RL17 a new drive command clears the flag
               av_fault[i] <= 1'b0;
            end
         end
         if (wr && paddr == `REG_AV_OUT) begin
            av_out <= pwdata[15:0] & ~flt_in;
            av_fault <= av_fault & ~pwdata[15:0];
         end
      end
   end

   // RL11 drive and sense simultaneously; RL10 sixteen lines
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avionics_shunt_line_oe <= 16'h0000;
      end else if (clk_en) begin
         avionics_shunt_line_oe <= av_out;
      end
   end

   // trigger evaluation on synchronised lines 0-2
   generate
      for (gi = 0; gi < `TRIG_COUNT; gi++) begin : g_trig
         // RL6 RL18 all masked lines match their polarity
         assign trig_hit[gi] = (trig_mask[gi*3 +: 3] != 3'h0) &&
            (((core_in[`TRIG_LINE_FIRST +: 3] ~^ trig_pol[gi*3 +: 3]) |
              ~trig_mask[gi*3 +: 3]) == 3'h7);
      end
   endgenerate

   // RL9 software fire equals external condition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_sync <= '0;
         trig_q <= 3'h0;
      end else if (clk_en) begin
         trig_sync.trig <= trig_hit | sw_fire;
         trig_sync.sync <= sync_request & sync_ctrl[2:0];
         trig_q <= trig_hit | sw_fire;
      end
   end
   assign trig_rise = (trig_hit | sw_fire) & ~trig_q;

   // configuration registers; sw_fire is a one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_mask <= 9'h000;
         trig_pol <= 9'h000;
         sync_ctrl <= 6'h00;
         sw_fire <= 3'h0;
         irq_mask <= 6'h00;
      end else if (clk_en) begin
         sw_fire <= 3'h0;
         if (wr && paddr == `REG_TRIG_MASK) trig_mask <= pwdata[8:0];
         if (wr && paddr == `REG_TRIG_POL) trig_pol <= pwdata[8:0];
         if (wr && paddr == `REG_SYNC_CTRL) sync_ctrl <= pwdata[5:0];
         if (wr && paddr == `REG_SW_FIRE) sw_fire <= pwdata[2:0];
         if (wr && paddr == `REG_IRQ_MASK) irq_mask <= pwdata[5:0];
      end
   end

   // sticky events: trigger rises and new faults; set beats read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 6'h00;
      end else if (clk_en) begin
         if (rd && paddr == `REG_IRQ_STATUS) begin
            irq_status <= {2'b00, trig_rise, |(flt_in & av_out)} |
                          {2'b00, 4'h0};
         end else begin
            irq_status <= irq_status | {2'b00, trig_rise, |(flt_in & av_out)};
         end
      end
   end
   assign irq = |(irq_status & irq_mask);

   // selector readback: last selector written picks a line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (cmd_go) begin
            sel_rdata <= 32'h0000_0000;
            if (cmd_sel >= `SEL_CORE_FIRST && cmd_sel <= `SEL_CORE_LAST)
               sel_rdata[0] <= core_in[3'(cmd_sel - `SEL_CORE_FIRST)];
            else if (cmd_sel >= `SEL_AV_FIRST && cmd_sel <= `SEL_AV_LAST)
               sel_rdata[0] <= av_in[4'(cmd_sel - `SEL_AV_FIRST)];
         end
      end
   end

   // read mux and error on unmapped address
   always_comb begin
      addr_ok = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         `REG_SEL_CMD: prdata = 32'h0000_0000;
         `REG_SEL_RDATA: prdata = sel_rdata;
         `REG_CORE_OUT: prdata = {24'h0, core_out};
         `REG_CORE_EN: prdata = {24'h0, core_en};
         `REG_CORE_IN: prdata = {24'h0, core_in};
         `REG_AV_OUT: prdata = {16'h0, av_out};
         `REG_AV_IN: prdata = {16'h0, av_in};
         `REG_AV_FAULT: prdata = {16'h0, av_fault};
         `REG_TRIG_MASK: prdata = {23'h0, trig_mask};
         `REG_TRIG_POL: prdata = {23'h0, trig_pol};
         `REG_SYNC_CTRL: prdata = {26'h0, sync_ctrl};
         `REG_SW_FIRE: prdata = 32'h0000_0000;
         `REG_IRQ_STATUS: prdata = {26'h0, irq_status};
         `REG_IRQ_MASK: prdata = {26'h0, irq_mask};
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;
endmodule // discrete_io_trigger_sync

// File: hw/discrete_io_defines.svh
// register offsets, field positions and reset values for the discrete block
`ifndef DISCRETE_IO_DEFINES_SVH
`define DISCRETE_IO_DEFINES_SVH
`define REG_SEL_CMD 12'h000
`define REG_SEL_RDATA 12'h004
`define REG_CORE_OUT 12'h008
`define REG_CORE_EN 12'h00C
`define REG_CORE_IN 12'h010
`define REG_AV_OUT 12'h014
`define REG_AV_IN 12'h018
`define REG_AV_FAULT 12'h01C
`define REG_TRIG_MASK 12'h020
`define REG_TRIG_POL 12'h024
`define REG_SYNC_CTRL 12'h028
`define REG_SW_FIRE 12'h02C
`define REG_IRQ_STATUS 12'h030
`define REG_IRQ_MASK 12'h034
`define CORE_LINES 8
`define AV_LINES 16
`define TRIG_COUNT 3
`define SEL_CORE_FIRST 6'h01
`define SEL_CORE_LAST 6'h08
`define SEL_AV_FIRST 6'h11
`define SEL_AV_LAST 6'h20
`define CMD_SEL_LSB 0
`define CMD_OP_LSB 8
`define CMD_VAL_BIT 12
`define TRIG_LINE_FIRST 0
`define SYNC_LINE_FIRST 4
`define CORE_EN_RESET 8'h00
`define AV_OUT_RESET 16'h0000
`endif

// File: hw/discrete_io_pkg.sv
// types shared by the discrete block
package discrete_io_pkg;
   typedef enum logic [3:0] {
      op_none,
      op_write,
      op_enable,
      op_release
   } sel_op_t;
   typedef struct packed {
      logic [31:0] paddr;
      logic pwrite;
      logic psel;
      logic penable;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [2:0] trig;
      logic [2:0] sync;
   } trig_out_t;
endpackage

// File: tb/discrete_io_trigger_sync_monitor.sv
// port checker for the discrete block
`timescale 1ns/10ps
`include "discrete_io_defines.svh"
module discrete_io_monitor (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic [7:0] core_discrete_line_i,
   input wire logic [7:0] core_discrete_line_o,
   input wire logic [7:0] core_discrete_line_oe,
   input wire logic [15:0] avionics_shunt_line_i,
   input wire logic [15:0] avionics_shunt_line_oe,
   input wire logic [15:0] avionics_thermal_fault,
   // protocol side
   input wire logic [2:0] sync_request,
   input wire discrete_io_pkg::trig_out_t trig_sync,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase and unmapped decode
   wire acc = psel && penable && clk_en;
   wire unm = (paddr > `REG_IRQ_MASK) || (paddr[1:0] != 2'h0);
   wire [15:0] f = avionics_thermal_fault;
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_unmapped_err: assert property (psel && penable |-> pslverr == unm)
      else $error("pslverr wrong");
   a_unmapped_zero: assert property (psel && penable && !pwrite && unm
      |-> prdata == 32'h0) else $error("unmapped read not zero");
   a_reset_open: assert property ($rose(presetn) |->
      core_discrete_line_oe == 8'h0 && avionics_shunt_line_oe == 16'h0)
      else $error("outputs driven after reset");
   // held fault must have dropped the drive; sync delay covered by depth
   a_fault_drop: assert property (((f & $past(f) & $past(f, 2) &
      $past(f, 3) & $past(f, 4) & $past(f, 5) & $past(f, 6)) &
      avionics_shunt_line_oe)
      == 16'h0) else $error("faulted line still sinking");
   // lines 3 and 7 are never owned, so they follow the register
   a_en_follow: assert property (acc && pwrite && paddr == `REG_CORE_EN |->
      ##2 core_discrete_line_oe[7] == $past(pwdata[7], 2) &&
      core_discrete_line_oe[3] == $past(pwdata[3], 2))
      else $error("enable not applied");
   a_out_follow: assert property (acc && pwrite && paddr == `REG_CORE_OUT
      |-> ##2 core_discrete_line_o[7] == $past(pwdata[7], 2) &&
      (core_discrete_line_oe[7] || !$past(pwdata[7], 2)))
      else $error("output write not applied");
   a_fire_pulse: assert property (acc && pwrite && paddr == `REG_SW_FIRE &&
      pwdata[1] |-> ##[1:3] trig_sync.trig[1])
      else $error("software fire missing");
endmodule // discrete_io_monitor
bind discrete_io_trigger_sync discrete_io_monitor mon (.*);

// File: tb/discrete_env.sv
// external discrete equipment seen at the pins
`timescale 1ns/10ps
module discrete_env (
   // pins from the block
   input wire logic [7:0] core_o,
   input wire logic [7:0] core_oe,
   input wire logic [15:0] av_oe,
   // far side stimulus
   input wire logic [7:0] ext_core,
   input wire logic [15:0] ext_gnd,
   // levels sensed by the block
   output logic [7:0] core_i,
   output logic [15:0] av_i
);
   // driven bits read back, released bits show far side
   assign core_i = (core_oe & core_o) | (~core_oe & ext_core);
   // pull-up reads open unless either side sinks
   assign av_i = ~(av_oe | ext_gnd);
endmodule // discrete_env

// File: tb/discrete_io_trigger_sync_tb.sv
// self-checking bench for the discrete block
`timescale 1ns/10ps
`include "discrete_io_defines.svh"
module discrete_io_trigger_sync_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [7:0] c_i, c_o, c_oe, ext;
   logic [15:0] a_i, a_oe, flt, gnd;
   logic [2:0] sreq;
   discrete_io_pkg::trig_out_t ts;
   int miscompares = 0, checked = 0, cyc = 0, en_m, out_m, k;
   // clk_en dropped once to prove that writes are frozen out
   discrete_io_trigger_sync uut (.pclk(pclk), .presetn(presetn),
      .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_discrete_line_i(c_i),
      .core_discrete_line_o(c_o), .core_discrete_line_oe(c_oe),
      .avionics_shunt_line_i(a_i), .avionics_shunt_line_oe(a_oe),
      .avionics_thermal_fault(flt), .sync_request(sreq),
      .trig_sync(ts), .irq(irq));
   discrete_env env (.core_o(c_o), .core_oe(c_oe), .av_oe(a_oe),
      .ext_core(ext), .ext_gnd(gnd), .core_i(c_i), .av_i(a_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sample pins away from the edge
   task wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task close_out;
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // cycle ceiling cuts a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         close_out;
      end
   end
   initial begin
      seed = 32'hDFEB;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ext, flt, gnd, sreq} = '0;
      ce = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      wt(1);
      chk("core_oe", c_oe, 0);
      chk("av_oe", a_oe, 0);
      apb(1'b0, 12'h038, 0);
      chk("pslverr", err, 1);
      chk("unmapped", rd, 0);
      // random enables and values against the pin model
      for (k = 0; k < 4; k++) begin
         @(posedge pclk);
         ext <= 8'(rnd());
         en_m = 8'(rnd());
         apb(1'b1, `REG_CORE_EN, en_m);
         out_m = 8'(rnd());
         apb(1'b1, `REG_CORE_OUT, out_m);
         en_m |= out_m;
         wt(6);
         chk("core_oe", c_oe, en_m);
         apb(1'b0, `REG_CORE_IN, 0);
         chk("core_in", rd, (en_m & out_m) | (~en_m & ext));
      end
      // every core selector: write drives, release lets go
      for (k = 1; k <= 8; k++) begin
         out_m = rnd() & 1;
         apb(1'b1, `REG_SEL_CMD, (out_m << 12) | (1 << 8) | k);
         wt(2);
         chk("sel_oe", c_oe[k-1], 1);
         chk("sel_o", c_o[k-1], out_m);
         apb(1'b1, `REG_SEL_CMD, (3 << 8) | k);
         wt(2);
         chk("rel_oe", c_oe[k-1], 0);
      end
      // every avionics selector sinks one line and reads it back
      for (k = 0; k < 16; k++) begin
         apb(1'b1, `REG_SEL_CMD, (1 << 12) | (1 << 8) | (k + 17));
         wt(6);
         chk("av_oe", a_oe, 1 << k);
         apb(1'b0, `REG_AV_IN, 0);
         chk("av_in", rd, 32'h0000FFFF ^ (1 << k));
         apb(1'b1, `REG_SEL_CMD, (1 << 8) | (k + 17));
      end
      @(posedge pclk);
      gnd <= 16'h8000;
      wt(6);
      apb(1'b0, `REG_AV_IN, 0);
      chk("av_gnd", rd, 32'h00007FFF);
      gnd <= 16'h0;
      // thermal fault, masked interrupt, latched flag, redrive
      apb(1'b1, `REG_AV_OUT, 3);
      @(posedge pclk);
      flt <= 16'h0001;
      wt(8);
      chk("fault_oe", a_oe, 2);
      apb(1'b0, `REG_AV_FAULT, 0);
      chk("flag", rd, 1);
      chk("irq_masked", irq, 0);
      apb(1'b1, `REG_IRQ_MASK, 1);
      wt(0);
      chk("irq", irq, 1);
      @(posedge pclk);
      flt <= 16'h0;
      wt(8);
      chk("still_off", a_oe, 2);
      apb(1'b0, `REG_IRQ_STATUS, 0);
      chk("status", rd[0], 1);
      wt(0);
      chk("irq_clr", irq, 0);
      apb(1'b1, `REG_AV_OUT, 3);
      wt(2);
      chk("redrive", a_oe, 3);
      apb(1'b0, `REG_AV_FAULT, 0);
      chk("flag_clr", rd, 0);
      // trigger A on line 0, which then leaves general use
      apb(1'b1, `REG_TRIG_MASK, 1);
      apb(1'b1, `REG_TRIG_POL, 1);
      apb(1'b1, `REG_CORE_EN, 8'hFF);
      @(posedge pclk);
      ext <= 8'h01;
      wt(6);
      chk("owned_oe", c_oe[0], 0);
      chk("trig_a", ts.trig[0], 1);
      @(posedge pclk);
      ext <= 8'h00;
      wt(6);
      chk("trig_off", ts.trig[0], 0);
      // sync A carried out on line 4
      apb(1'b1, `REG_SYNC_CTRL, 1);
      for (k = 0; k < 2; k++) begin
         @(posedge pclk);
         sreq <= 3'(k ^ 1);
         wt(3);
         chk("sync_a", c_o[4], k ^ 1);
         chk("sync_out", ts.sync[0], k ^ 1);
      end
      // a write while the clock enable is low must not land
      @(posedge pclk);
      ce <= 1'b0;
      apb(1'b1, `REG_CORE_EN, 0);
      ce <= 1'b1;
      apb(1'b0, `REG_CORE_EN, 0);
      chk("frozen_en", rd, 32'h000000FF);
      apb(1'b1, `REG_SW_FIRE, 2);
      wt(1);
      apb(1'b0, `REG_IRQ_STATUS, 0);
      chk("fire_irq", rd[2], 1);
      close_out;
   end
endmodule // discrete_io_trigger_sync_tb
